// ### hdl/ctr_pkg.sv
// Purpose: shared constants and types of the counter event / cam unit
// Assumes: one 50 MHz clock, register port with one-cycle read latency
// Notes:   offsets are byte addresses on the plain register port
`default_nettype none
package ctr_pkg;
    localparam int          CLK_HZ       = 50_000_000;
    localparam int          ADDR_W       = 8;
    localparam int          DATA_W       = 32;
    localparam int          MAX_STEPS    = 16;
    // register offsets
    localparam logic [7:0]  OFS_EVT_CFG  = 8'h00;
    localparam logic [7:0]  OFS_CAM_CFG  = 8'h04;
    localparam logic [7:0]  OFS_COUNT    = 8'h08;
    localparam logic [7:0]  OFS_STATUS   = 8'h0C;
    localparam logic [7:0]  OFS_STEP0    = 8'h40;
    // event config fields: per event, [1:0] source/condition
    localparam int          EVT_SEL_POS  = 0;
    localparam int          EVT_CND_POS  = 1;
    localparam int          EVT_ENA_POS  = 2;
    localparam int          EVT_FLD_W    = 4;
    localparam int          EVT_UD_POS   = 8;
    // cam config fields
    localparam int          CAM_INIT_POS = 0;
    localparam int          CAM_ENA_POS  = 1;
    localparam int          CAM_NUM_POS  = 8;
    localparam int          CAM_NUM_W    = 5;
    localparam logic [31:0] EVT_CFG_RST  = 32'h0000_0000;
    localparam logic [31:0] CAM_CFG_RST  = 32'h0000_0000;
    // variant selection
    typedef enum logic [0:0] {WIDTH_16, WIDTH_32} width_variant_t;
endpackage
`default_nettype wire

// ### hdl/sync_bus_if.sv
// Purpose: carries synchronised phase levels and their qualified edges
// Assumes: produced and consumed on clk
// Notes:   rise/fall are one-cycle pulses
`default_nettype none
interface sync_bus_if;
    logic [1:0] level;   // filtered phase levels, bit0 = A, bit1 = B
    logic [1:0] rise;    // one-cycle rising edge pulses
    logic [1:0] fall;    // one-cycle falling edge pulses
    modport src (output level, rise, fall);
    modport dst (input  level, rise, fall);
endinterface
`default_nettype wire

// ### hdl/phase_sync.sv
// Purpose: three-stage synchroniser and edge finder for both phase pins
// Assumes: pins are asynchronous to clk
// Notes:   a change counts once stages two and three agree
`default_nettype none
module phase_sync (
    input  wire logic  clk,     // module clock
    input  wire logic  arst_n,  // async reset, active low
    input  wire logic [1:0] pin, // raw phase pins
    sync_bus_if.src    sb       // synchronised outputs
);
    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
        logic [1:0] s3;
        logic [1:0] lvl;
        logic [1:0] rise;
        logic [1:0] fall;
    } state_t;
    state_t q, d;

    // --------------------------------------------------------------
    // next state
    // --------------------------------------------------------------
    always_comb begin
        d      = q;
        d.s1   = pin;
        d.s2   = q.s1;   // first stage read only here
        d.s3   = q.s2;
        d.rise = 2'b00;
        d.fall = 2'b00;
        for (int i = 0; i < 2; i++) begin
            // accept a new level only when stages two and three agree
            if (q.s2[i] == q.s3[i] && q.s3[i] != q.lvl[i]) begin
                d.lvl[i]  = q.s3[i];
                d.rise[i] = q.s3[i];
                d.fall[i] = ~q.s3[i];
            end
        end
    end

    // registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign sb.level = q.lvl;
    assign sb.rise  = q.rise;
    assign sb.fall  = q.fall;
endmodule // phase_sync
`default_nettype wire

// ### hdl/ctr_event_cam.sv
// Purpose: counter unit with event generation and cam-switch output
// Assumes: pins asynchronous; register port one-cycle read latency
// Notes:   VARIANT selects 16-bit (events) or 32-bit (cam) build
//
// Behaviour
// - one unit offers at most two generated event outputs
// - event generation exists only in the 16-bit variant
// - each event detects rising edge or high level of phase A or B
// - edge mode: event pulses high then low on each input rise
// - level mode: event follows the input level high and low
// - event outputs are ports that feed other counter units
// - cam output exists only in the 32-bit variant
// - below first threshold the cam output holds a set initial level
// - step total enables thresholds zero to total minus one
// - each enabled step holds its own count threshold
// - cam output inverts each time the count reaches a threshold
// - counter adds one per count-up pulse unless a down pulse comes in the same cycle
// - detector makes up and down pulses from the two phases
`default_nettype none
module ctr_event_cam
    import ctr_pkg::*;
#(
    parameter ctr_pkg::width_variant_t VARIANT = ctr_pkg::WIDTH_32,
    parameter int                      STEPS   = ctr_pkg::MAX_STEPS
) (
    input  wire logic                      clk,       // 50 MHz clock
    input  wire logic                      arst_n,    // async reset, low
    input  wire logic [1:0]                phase_in,  // field pins A, B
    input  wire logic [ctr_pkg::ADDR_W-1:0] addr,     // register address
    input  wire logic [ctr_pkg::DATA_W-1:0] wdata,    // write data
    input  wire logic                      wr,        // write strobe
    input  wire logic                      rd,        // read strobe
    output logic      [ctr_pkg::DATA_W-1:0] rdata,    // read data
    output logic      [1:0]                event_out, // events 0 and 1
    output logic                           cam_out    // cam switch pin
);
    import ctr_pkg::*;

    localparam int CNT_W = (VARIANT == WIDTH_16) ? 16 : 32;
    localparam bit HAS_EVT = (VARIANT == WIDTH_16);
    localparam bit HAS_CAM = (VARIANT == WIDTH_32);

    // --------------------------------------------------------------
    // synchronised phase inputs
    // --------------------------------------------------------------
    sync_bus_if sb ();

    phase_sync u_sync (
        .clk    (clk),
        .arst_n (arst_n),
        .pin    (phase_in),
        .sb     (sb)
    );

    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    typedef struct packed {
        logic [31:0]              evt_cfg;
        logic [31:0]              cam_cfg;
        logic [STEPS-1:0][31:0]   step_thr;
        logic [31:0]              count;
        logic [CAM_NUM_W-1:0]     step_idx;
        logic                     cam;
        logic [1:0]               evt;
        logic [31:0]              rdata;
    } state_t;
    state_t q, d;

    // step total, clamped to the number of built steps
    function automatic logic [CAM_NUM_W-1:0] step_total(
        input logic [31:0] cfg);
        logic [CAM_NUM_W-1:0] n;
        n = cfg[CAM_NUM_POS +: CAM_NUM_W];
        if (n > CAM_NUM_W'(STEPS)) begin
            n = CAM_NUM_W'(STEPS);
        end
        return n;
    endfunction

    // one event field: selected phase, edge or level
    function automatic logic evt_hit(input logic [3:0] f,
                                     input logic [1:0] lvl,
                                     input logic [1:0] rise);
        logic src_b;
        src_b = f[EVT_SEL_POS];
        if (!f[EVT_ENA_POS]) begin
            return 1'b0;
        end
        if (f[EVT_CND_POS]) begin
            return src_b ? lvl[1] : lvl[0];
        end
        return src_b ? rise[1] : rise[0];
    endfunction

    logic                 cnt_up;
    logic                 cnt_dn;
    logic [CAM_NUM_W-1:0] enabled_step_total;
    logic                 ud_mode;

    // --------------------------------------------------------------
    // next state
    // --------------------------------------------------------------
    always_comb begin
        d = q;
        enabled_step_total = step_total(q.cam_cfg);
        ud_mode = q.evt_cfg[EVT_UD_POS];

        // up pulse from phase A rise, down from phase B rise
        cnt_up = ud_mode && sb.rise[0];
        cnt_dn = ud_mode && sb.rise[1];

        // events only built in 16-bit variant, two of them
        for (int e = 0; e < 2; e++) begin
            d.evt[e] = HAS_EVT &&
                evt_hit(q.evt_cfg[e*EVT_FLD_W +: EVT_FLD_W],
                        sb.level, sb.rise);
        end

        // counter: one per pulse; both at once cancel
        if (cnt_up && !cnt_dn) begin
            d.count = q.count + 32'h0000_0001;
        end else if (cnt_dn && !cnt_up) begin
            d.count = q.count - 32'h0000_0001;
        end
        if (CNT_W == 16) begin
            d.count[31:16] = 16'h0000;
        end

        // cam: walk the thresholds as the count crosses them
        if (HAS_CAM && q.cam_cfg[CAM_ENA_POS]) begin
            if (q.step_idx < enabled_step_total &&
                d.count >= q.step_thr[q.step_idx]) begin
                d.step_idx = q.step_idx + 1'b1;
                d.cam      = ~q.cam;
            end else if (q.step_idx != '0 &&
                d.count < q.step_thr[q.step_idx - 1'b1]) begin
                // counting down back through a threshold undoes it
                d.step_idx = q.step_idx - 1'b1;
                d.cam      = ~q.cam;
            end
        end else begin
            d.step_idx = '0;
            d.cam      = HAS_CAM & q.cam_cfg[CAM_INIT_POS];
        end

        // register writes
        if (wr) begin
            case (addr)
                OFS_EVT_CFG: d.evt_cfg = wdata;
                OFS_CAM_CFG: begin
                    d.cam_cfg  = wdata;
                    d.step_idx = '0;           // restart the cam walk
                    d.cam      = HAS_CAM & wdata[CAM_INIT_POS];
                end
                OFS_COUNT: begin
                    d.count    = wdata;
                    d.step_idx = '0;
                    d.cam      = HAS_CAM & q.cam_cfg[CAM_INIT_POS];
                end
                default: begin
                    for (int s = 0; s < STEPS; s++) begin
                        if (addr == ADDR_W'(OFS_STEP0 + 4 * s)) begin
                            d.step_thr[s] = wdata;
                        end
                    end
                end
            endcase
        end

        // register reads: data in the next cycle only
        d.rdata = '0;
        if (rd) begin
            case (addr)
                OFS_EVT_CFG: d.rdata = q.evt_cfg;
                OFS_CAM_CFG: d.rdata = q.cam_cfg;
                OFS_COUNT:   d.rdata = q.count;
                OFS_STATUS:  d.rdata = {24'h00_0000, q.step_idx,
                                        q.evt, q.cam};
                default: begin
                    for (int s = 0; s < STEPS; s++) begin
                        if (addr == ADDR_W'(OFS_STEP0 + 4 * s)) begin
                            d.rdata = q.step_thr[s];
                        end
                    end
                end
            endcase
        end
    end

    // registers; state cleared to defaults on reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q         <= '0;
            q.evt_cfg <= EVT_CFG_RST;
            q.cam_cfg <= CAM_CFG_RST;
        end else begin
            q <= d;
        end
    end

    // outputs straight from flops; events feed other units
    assign rdata     = q.rdata;
    assign event_out = q.evt;
    assign cam_out   = q.cam;
endmodule // ctr_event_cam
`default_nettype wire

// ### tb/field_pins.sv
// Purpose: field side model driving the two phase pins
// Assumes: pins follow the requested level after one cycle plus lag cycles
// Notes:   lag lets the field answer promptly or slowly
`default_nettype none
module field_pins (
    input  wire logic [0:0] clk,  // module clock
    input  wire logic [1:0] want, // requested levels
    input  wire logic [2:0] lag,  // extra delay, cycles
    output var  logic [1:0] pin   // phase pins A, B
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] wait_q = 3'h0;
    // ----------------------------------------
    // pins never move faster than clk sees them
    // ----------------------------------------
    initial pin = 2'b00;
    always @(posedge clk) begin
        if (pin == want) wait_q <= 3'h0;
        else if (wait_q >= lag) pin <= want;
        else wait_q <= wait_q + 3'h1;
    end
endmodule // field_pins
`default_nettype wire

// ### tb/ctr_event_cam_sva.sv
// Purpose: port checks of the counter event / cam unit
// Assumes: config shadowed from bus writes
// Notes:   event checks wait 15 cycles after an event config write
`default_nettype none
module ctr_event_cam_chk
    import ctr_pkg::*;
#(
    parameter ctr_pkg::width_variant_t VARIANT = ctr_pkg::WIDTH_32,
    parameter int                      STEPS   = ctr_pkg::MAX_STEPS
) (
    input wire logic                       clk,       // clock
    input wire logic                       arst_n,    // reset, low
    input wire logic [1:0]                 phase_in,  // pins
    input wire logic [ctr_pkg::ADDR_W-1:0] addr,      // address
    input wire logic [ctr_pkg::DATA_W-1:0] wdata,     // write data
    input wire logic                       wr,        // write strobe
    input wire logic [1:0]                 event_out, // events
    input wire logic                       cam_out    // cam pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] ev_q, cam_q, thr_q;
    logic [3:0]  age_q;
    logic        e16, w32, ok, lvl1;
    // shadow config: the checker cannot see the registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ev_q  <= EVT_CFG_RST;
            cam_q <= CAM_CFG_RST;
            thr_q <= 32'h0;
            age_q <= 4'h0;
        end else begin
            if (wr && addr == OFS_EVT_CFG) ev_q <= wdata;
            if (wr && addr == OFS_CAM_CFG) cam_q <= wdata;
            if (wr && addr == OFS_STEP0) thr_q <= wdata;
            age_q <= (wr && addr == OFS_EVT_CFG) ? 4'h0 :
                     (age_q == 4'hF) ? age_q : age_q + 4'h1;
        end
    end
    assign e16  = VARIANT == WIDTH_16;
    assign w32  = VARIANT == WIDTH_32;
    assign ok   = age_q == 4'hF;
    assign lvl1 = ev_q[6:4] == 3'b111;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    property p_evt32; w32 |-> event_out == 2'b00; endproperty
    a_evt32: assert property (p_evt32)
        else $error("event from wide build");
    property p_cam16; e16 |-> !cam_out; endproperty
    a_cam16: assert property (p_cam16)
        else $error("cam from narrow build");
    property p_off; e16 && ok && !ev_q[2] |-> !event_out[0]; endproperty
    a_off: assert property (p_off)
        else $error("disabled event fired");
    property p_edge;
        e16 && ok && ev_q[2:0] == 3'b100 && $rose(phase_in[0]) ##1
        phase_in[0] |-> ##[0:7] event_out[0];
    endproperty
    a_edge: assert property (p_edge)
        else $error("edge event missing");
    property p_one;
        e16 && ok && ev_q[2:1] == 2'b10 && event_out[0] |=> !event_out[0];
    endproperty
    a_one: assert property (p_one)
        else $error("edge event too long");
    property p_hi; e16 && ok && lvl1 && phase_in[1] [*8] |-> event_out[1];
    endproperty
    a_hi: assert property (p_hi)
        else $error("level event not high");
    property p_lo; e16 && ok && lvl1 && !phase_in[1] [*8] |-> !event_out[1];
    endproperty
    a_lo: assert property (p_lo)
        else $error("level event not low");
    property p_init;
        w32 && cam_q[1] && wr && addr == OFS_COUNT && wdata < thr_q
        |-> ##[1:3] cam_out == cam_q[0];
    endproperty
    a_init: assert property (p_init)
        else $error("cam not at initial level");
    c_pulse: cover property (e16 && $rose(event_out[0]));
    c_level: cover property (e16 && lvl1 && event_out[1]);
    c_cam: cover property (w32 && $changed(cam_out));
endmodule // ctr_event_cam_chk
bind ctr_event_cam ctr_event_cam_chk #(.VARIANT(VARIANT), .STEPS(STEPS)) chk (
    .clk(clk), .arst_n(arst_n), .phase_in(phase_in), .addr(addr),
    .wdata(wdata), .wr(wr), .event_out(event_out), .cam_out(cam_out));
`default_nettype wire

// ### tb/testbench.sv
// Purpose: self-checking bench for the counter event / cam unit
// Assumes: both builds share the bus and the field pins
// Notes:   random count walk, fixed seed for repeatability
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import ctr_pkg::*;
    logic        clk, arst_n, wr, rd, cam32, cam16, init;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, rd16, got;
    logic [1:0]  want, ph, ev32, ev16, prev;
    logic [2:0]  lag;
    int          failures, compares, seed, cnt, n, rises[2], highs[2];
    field_pins fp (.clk(clk), .want(want), .lag(lag), .pin(ph));
    ctr_event_cam #(.VARIANT(WIDTH_32)) dut (.clk(clk), .arst_n(arst_n),
        .phase_in(ph), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .event_out(ev32), .cam_out(cam32));
    ctr_event_cam #(.VARIANT(WIDTH_16)) dut_ev (.clk(clk), .arst_n(arst_n),
        .phase_in(ph), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rd16), .event_out(ev16), .cam_out(cam16));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // count event rises and high cycles of the narrow build
    always @(posedge clk) begin
        for (int k = 0; k < 2; k++) begin
            if (ev16[k] && !prev[k]) rises[k]++;
            if (ev16[k]) highs[k]++;
        end
        prev <= ev16;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h, want %h", $time, seen, exp);
        end
    endtask
    task automatic conclude;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk) got = rdata;
    endtask
    // pins move, then settle long enough for the synchroniser
    task automatic pins(input logic [1:0] v);
        @(posedge clk);
        lag  <= 3'($random(seed));
        want <= v;
        for (int i = 0; i < 20 && ph !== v; i++) @(posedge clk);
        if (ph !== v) begin
            failures++;
            conclude;
        end
        repeat (8) @(posedge clk);
        @(negedge clk);
    endtask
    function automatic logic expc(int c, int m, logic i0);
        logic v;
        v = i0;
        for (int s = 0; s < m; s++) if (c >= 2 * s + 2) v = ~v;
        return v;
    endfunction
    initial begin
        repeat (100000) @(posedge clk);
        failures++;
        conclude;
    end
    initial begin
        {seed, failures, compares} = {32'd58, 32'd0, 32'd0};
        {arst_n, wr, rd, addr, wdata, want, lag, prev} = '0;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        @(negedge clk);
        check(32'({cam32, cam16, ev32, ev16}), 32'h0);
        rreg(OFS_EVT_CFG);
        check(got, EVT_CFG_RST);
        rreg(OFS_CAM_CFG);
        check(got, CAM_CFG_RST);
        rreg(8'h3C);
        check(got, 32'h0);
        $display("reset test done");
        // source A/B, rise/high, then disabled; both events alike
        for (int c = 0; c < 5; c++) begin
            wreg(OFS_EVT_CFG, 32'((c < 4 ? 4 + c : 0) * 17));
            rises = '{0, 0};
            highs = '{0, 0};
            repeat (3) begin
                pins(c[0] ? 2'b10 : 2'b01);
                check(ev16, (c < 4 && c[1]) ? 2'b11 : 2'b00);
                check(ev32, 2'b00);
                pins(2'b00);
                check(ev16, 2'b00);
            end
            check(32'(rises[0] + rises[1]), c < 4 ? 6 : 0);
            if (c < 4 && !c[1]) check(32'(highs[0] + highs[1]), 6);
        end
        $display("event test done");
        // cam: random up/down walk across the thresholds
        for (int r = 0; r < 2; r++) begin
            n = r ? 3 : 7;
            init = 1'($random(seed));
            wreg(OFS_EVT_CFG, 32'h0000_0100);
            for (int s = 0; s < 7; s++) wreg(OFS_STEP0 + 8'(4 * s), 32'(2 * s + 2));
            wreg(OFS_CAM_CFG, {19'h0, 5'(n), 6'h0, 1'b1, init});
            wreg(OFS_COUNT, 32'h0);
            @(negedge clk);
            check(cam32, init);
            cnt = 0;
            repeat (30) begin
                if (cnt == 0 || ($random(seed) & 3) != 0) begin
                    pins(2'b01);
                    cnt++;
                end else begin
                    pins(2'b10);
                    cnt--;
                end
                pins(2'b00);
                rreg(OFS_COUNT);
                check(got, 32'(cnt));
                check(cam32, expc(cnt, n, init));
                rreg(OFS_STATUS);
                check(got[0], expc(cnt, n, init));
            end
        end
        $display("cam test done");
        conclude;
    end
endmodule // testbench
`default_nettype wire
